/* File: verilog/soft_ctrl.sv */
// Purpose: Soft control and status logic of a pluggable module.
// Assumes: scl, sda, select, reset, low power and flag inputs are asynchronous.
// Notes: Register access by the host happens over the two-wire slave.
// Summary of operation
// - Setting a mask bit stops its flag pulling the interrupt line low.
// - Clearing a mask bit lets its flag drive the interrupt line again.
// - Active module select lets the slave answer serial transfers quickly.
// - Inactive module select makes the slave stop answering quickly.
// - Setting power override or power set enters low power.
// - Clearing them returns to fully functional within 300 ms.
// - Fully functional shows as not-ready cleared plus an interrupt.
// - Write effects take place no later than the edge after stop.
// - Read effects take place no later than the edge after stop.
// - A read that clears a flag releases the interrupt line.
// - A flag condition sets its flag and asserts the interrupt line.
// - Low power input enters low power within 100 us.
`timescale 1ns/1ps
`default_nettype none
module soft_ctrl
    import soft_ctrl_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int FLAG_W = 4
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic module_select_line_n,
    input wire logic module_reset_line_n,
    input wire logic low_power_input,
    input wire logic [FLAG_W-1:0] flag_cond,
    output logic interrupt_line_n,
    output logic presence_output_n,
    output logic low_power_state
);
    // Synchroniser stages for every asynchronous input.
    localparam int NSYNC = FLAG_W + 5;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic scl_d;
    logic sda_d;
    wire logic [NSYNC-1:0] async_in = {flag_cond, low_power_input,
        module_reset_line_n, module_select_line_n, sda_i, scl_i};
    // Stages reset to each pin's idle level, so release shows no false event.
    localparam logic [NSYNC-1:0] SYNC_IDLE = {{FLAG_W{1'b0}}, 5'h0F};

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else if (ce)
        begin
            sync1 <= async_in;
            sync2 <= sync1;
            scl_d <= sync2[0];
            sda_d <= sync2[1];
        end

    // Named views of the synchronised pins and their edges.
    wire logic scl_s = sync2[0];
    wire logic sda_s = sync2[1];
    wire logic selected = ~sync2[2];
    wire logic mrst_n_s = sync2[3];
    wire logic lp_in_s = sync2[4];
    wire logic [FLAG_W-1:0] cond_s = sync2[NSYNC-1:5];
    wire logic scl_rise = scl_s & ~scl_d;
    wire logic scl_fall = ~scl_s & scl_d;
    wire logic start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire logic stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // Module reset pin filter: only a low longer than the minimum counts.
    logic [8:0] rst_cnt;
    logic soft_rst;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            rst_cnt <= '0;
        else if (ce)
            rst_cnt <= mrst_n_s ? '0 : rst_cnt + {8'h00, ~soft_rst};
    assign soft_rst = (rst_cnt >= 9'(RESET_MIN_CYC));

    // Two-wire slave engine and its module memory.
    ser_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic first_byte;
    logic wr_seen;
    logic rd_seen;
    logic [7:0] mask;
    logic [7:0] pend_mask;
    logic [1:0] power;
    logic [1:0] pend_power;
    logic [7:0] flags;
    logic [7:0] rd_clear;
    logic not_ready;
    logic [6:0] slave_addr;

    // Byte returned for a read of the module memory.
    function automatic logic [7:0] mem_read(input logic [7:0] a,
        input logic [7:0] fl, input logic [7:0] mk, input logic [1:0] pw,
        input logic nr);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            MEM_STATUS: r[NOT_READY_BIT] = nr;
            MEM_FLAGS: r = fl;
            MEM_MASK: r = mk;
            MEM_POWER: r = {6'h00, pw};
            default: r = 8'h00;
        endcase
        return r;
    endfunction : mem_read

    wire logic [7:0] rd_byte = mem_read(ptr, flags, mask, power, not_ready);
    wire logic byte_done = (bitcnt == 4'h8);
    wire logic addr_hit = (shreg[7:1] == slave_addr) & selected;
    wire logic commit = stop_det & (state != SER_IDLE);

    // Serial state machine; a released select aborts at once.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            state <= SER_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            sda_oe <= 1'b0;
        end
        else if (ce)
        begin
            if (!selected || soft_rst)
            begin
                state <= SER_IDLE;
                sda_oe <= 1'b0;
            end
            else if (start_det)
            begin
                state <= SER_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (stop_det)
            begin
                state <= SER_IDLE;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
                case (state)
                    SER_ADDR, SER_WRITE:
                    begin
                        shreg <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    SER_READ:
                    begin
                        shreg <= {shreg[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    SER_ACK_R:
                        if (sda_s)
                            state <= SER_WAIT;
                    default: state <= state;
                endcase
            else if (scl_fall)
                case (state)
                    SER_ADDR:
                        if (byte_done && addr_hit)
                        begin
                            state <= SER_ACK_A;
                            sda_oe <= 1'b1;
                        end
                        else if (byte_done)
                            state <= SER_WAIT;
                    SER_WRITE:
                        if (byte_done)
                        begin
                            state <= SER_ACK_W;
                            sda_oe <= 1'b1;
                        end
                    SER_ACK_W:
                    begin
                        state <= SER_WRITE;
                        bitcnt <= 4'h0;
                        sda_oe <= 1'b0;
                    end
                    SER_ACK_A, SER_ACK_R:
                        if (state == SER_ACK_R || shreg[0])
                        begin
                            state <= SER_READ;
                            bitcnt <= 4'h0;
                            shreg <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                        end
                        else
                        begin
                            state <= SER_WRITE;
                            bitcnt <= 4'h0;
                            sda_oe <= 1'b0;
                        end
                    SER_READ:
                        if (byte_done)
                        begin
                            state <= SER_ACK_R;
                            sda_oe <= 1'b0;
                        end
                        else
                            sda_oe <= ~shreg[7];
                    default: state <= state;
                endcase
        end
    assign sda_o = 1'b0;

    // Pointer, pending writes and read bookkeeping of one transaction.
    wire logic wbyte = scl_fall & (state == SER_WRITE) & byte_done & selected;
    wire logic rbyte = scl_fall & (state == SER_ACK_A || state == SER_ACK_R)
        & (state == SER_ACK_R || shreg[0]) & selected;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            ptr <= 8'h00;
            first_byte <= 1'b0;
            wr_seen <= 1'b0;
            rd_seen <= 1'b0;
            pend_mask <= MASK_RST;
            pend_power <= 2'h0;
            rd_clear <= 8'h00;
        end
        else if (ce)
        begin
            if (start_det)
            begin
                first_byte <= 1'b1;
                wr_seen <= 1'b0;
                rd_seen <= 1'b0;
                rd_clear <= 8'h00;
                pend_mask <= mask;
                pend_power <= power;
            end
            else if (wbyte && first_byte)
            begin
                ptr <= shreg;
                first_byte <= 1'b0;
            end
            else if (wbyte)
            begin
                wr_seen <= 1'b1;
                ptr <= ptr + 8'h01;
                if (ptr == MEM_MASK)
                    pend_mask <= shreg;
                if (ptr == MEM_POWER)
                    pend_power <= shreg[1:0];
            end
            else if (rbyte)
            begin
                rd_seen <= 1'b1;
                ptr <= ptr + 8'h01;
                if (ptr == MEM_FLAGS)
                    rd_clear <= rd_clear | flags;
            end
        end

    // Write and read effects are committed at the stop condition itself,
    // which is ahead of the falling edge that starts each deadline.
    wire logic commit_wr = commit & wr_seen;
    wire logic commit_rd = commit & rd_seen;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            mask <= MASK_RST;
            power <= 2'h0;
        end
        else if (ce && soft_rst)
        begin
            mask <= MASK_RST;
            power <= 2'h0;
        end
        else if (ce && commit_wr)
        begin
            mask <= pend_mask;
            power <= pend_power;
        end

    // Low power and the wake-up sequence back to full function.
    logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt;
    wire logic next_low_power = power[POWER_OVR_BIT] | power[POWER_SET_BIT]
        | lp_in_s;
    wire logic ready_event = not_ready & ~low_power_state & ~next_low_power
        & ~soft_rst & (wake_cnt == '0);
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            low_power_state <= 1'b1;
            not_ready <= 1'b1;
            wake_cnt <= ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES); // Full wait.
        end
        else if (ce)
        begin
            low_power_state <= next_low_power | soft_rst;
            if (next_low_power || soft_rst)
            begin
                not_ready <= 1'b1;
                wake_cnt <= ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES);
            end
            else if (wake_cnt != '0)
                wake_cnt <= wake_cnt - 1'b1;
            else if (ready_event)
                not_ready <= 1'b0;
        end

    // Latched flags: a setting event wins over a clear by read.
    wire logic [7:0] flag_set = {{(7-FLAG_W){1'b0}}, cond_s, ready_event};
    wire logic [7:0] flag_clr = commit_rd ? rd_clear : 8'h00;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            flags <= 8'h00;
        else if (ce)
            flags <= soft_rst ? 8'h00 : (flags & ~flag_clr) | flag_set;

    // Interrupt line, low while any unmasked flag is set.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            interrupt_line_n <= 1'b1;
        else if (ce)
            interrupt_line_n <= ~|(flags & ~mask);
    assign presence_output_n = 1'b0;

    // AHB-Lite slave: zero wait states, always OKAY.
    ahb_phase_s aph;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic sel_d;
    wire logic take = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire logic wr_ctrl = aph.valid & aph.write & (aph.addr == REG_CTRL);
    wire logic wr_imask = aph.valid & aph.write & (aph.addr == REG_IRQ_MASK);
    wire logic wr_istat = aph.valid & aph.write
        & (aph.addr == REG_IRQ_STATUS);
    wire logic [3:0] ev = {commit_rd, ready_event, commit_wr,
        selected & ~sel_d};
    wire logic [3:0] w1c = wr_istat ? hwdata[3:0] : 4'h0;
    wire logic [7:0] rsel = haddr[7:0];
    wire logic [31:0] next_hrdata =
        (rsel == REG_IRQ_STATUS) ? {28'h0, irq_status} :
        (rsel == REG_IRQ_MASK) ? {28'h0, irq_mask} :
        (rsel == REG_CTRL) ? {25'h0, slave_addr} :
        (rsel == REG_STATE) ? {28'h0, ~interrupt_line_n, low_power_state,
            not_ready, selected} :
        (rsel == REG_FLAGS) ? {24'h0, flags} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            aph <= '0;
            hrdata <= 32'h0;
        end
        else if (ce)
        begin
            aph <= '{valid: take, write: hwrite, addr: haddr[7:0]};
            if (take && !hwrite)
                hrdata <= next_hrdata;
        end

    // Bus registers; hardware events win over write-one-to-clear.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            irq_status <= 4'h0;
            irq_mask <= IRQ_MASK_RST;
            slave_addr <= SLAVE_ADDR_RST;
            sel_d <= 1'b0;
        end
        else if (ce)
        begin
            sel_d <= selected;
            irq_status <= (irq_status & ~w1c) | ev;
            if (wr_imask)
                irq_mask <= hwdata[3:0];
            if (wr_ctrl)
                slave_addr <= hwdata[6:0];
        end
    assign irq = |(irq_status & irq_mask);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Checks on the observable behaviour.
    sequence write_commit_s;
        commit_wr;
    endsequence
    sequence read_commit_s;
        commit_rd && (rd_clear != 8'h00);
    endsequence
    mask_inhibits_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) write_commit_s ##1 (mask == 8'hFF)
        |-> ##1 interrupt_line_n)
        else $error("masked flags still drive the interrupt line");
    mask_resumes_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) (flags[0] && !mask[0]) |-> ##1
        !interrupt_line_n)
        else $error("unmasked flag does not drive the interrupt line");
    select_answers_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) (state == SER_ADDR && scl_fall
        && byte_done && addr_hit && !soft_rst) |=>
        (state == SER_ACK_A && sda_oe))
        else $error("matching address not acknowledged while selected");
    deselect_quiet_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) !selected |=> !sda_oe)
        else $error("data line driven while not selected");
    power_down_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) $rose(power != 2'h0) |=>
        low_power_state)
        else $error("power bit did not enter low power");
    wake_up_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) $fell(low_power_state) |->
        not_ready throughout (wake_cnt != '0) [*1])
        else $error("wake sequence not started");
    ready_flag_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) $fell(not_ready) |-> flags[0]
        ##0 (mask[0] or (##1 !interrupt_line_n)))
        else $error("ready without flag and interrupt");
    write_effect_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce || soft_rst) write_commit_s |=>
        (mask == $past(pend_mask)))
        else $error("written mask not committed at stop");
    read_release_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) read_commit_s ##1
        ((flags & ~mask) == 8'h00) |=> interrupt_line_n)
        else $error("interrupt line held after read clear");
    flag_set_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) (cond_s[0] && !soft_rst) |=>
        flags[1] ##0 (mask[1] or (##1 !interrupt_line_n)))
        else $error("flag condition not latched");
    lp_input_a: assert property (@(posedge hclk)
        disable iff (!hresetn || !ce) lp_in_s |=> low_power_state)
        else $error("low power input ignored");
endmodule : soft_ctrl
`default_nettype wire

/* File: verilog/soft_ctrl_pkg.sv */
// Purpose: Shared constants and carriers of the module soft control block.
// Assumes: hclk runs at 125 MHz.
// Notes: Two-wire byte offsets and bus offsets are held here only.
package soft_ctrl_pkg;
    // Clock rate and derived cycle counts.
    localparam int CLK_MHZ = 125;
    localparam int T_RESET_MIN_US = 2;
    localparam int RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;
    localparam int T_WAKE_US = 1000;
    localparam int WAKE_CYC = T_WAKE_US * CLK_MHZ;
    // Two-wire memory byte offsets.
    localparam logic [7:0] MEM_STATUS = 8'h02;
    localparam logic [7:0] MEM_FLAGS = 8'h03;
    localparam logic [7:0] MEM_POWER = 8'h5D;
    localparam logic [7:0] MEM_MASK = 8'h64;
    // Field positions.
    localparam int NOT_READY_BIT = 0;
    localparam int FLAG_READY_BIT = 0;
    localparam int POWER_OVR_BIT = 0;
    localparam int POWER_SET_BIT = 1;
    // Bus register byte addresses.
    localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
    localparam logic [7:0] REG_IRQ_MASK = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0C;
    localparam logic [7:0] REG_FLAGS = 8'h10;
    // Reset values.
    localparam logic [6:0] SLAVE_ADDR_RST = 7'h50;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    // Event bits of the bus status register.
    localparam int EV_SELECT = 0;
    localparam int EV_WRITE = 1;
    localparam int EV_READY = 2;
    localparam int EV_READ = 3;
    // AHB transfer type.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // Serial engine states.
    typedef enum logic [2:0] {
        SER_IDLE, SER_ADDR, SER_ACK_A, SER_WRITE, SER_ACK_W, SER_READ,
        SER_ACK_R, SER_WAIT
    } ser_state_e;
    // Latched address phase of a bus transfer.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_phase_s;
endpackage : soft_ctrl_pkg

/* File: verification/host_model.sv */
// Purpose: Two-wire host controller that talks to the module's serial slave.
// Assumes: The data line has a pull-up; the link clock idles high.
// Notes: Bit half periods give a 125 ns serial clock, free of the hclk phase.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // The link clock stands high between frames and the data line is released.
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // One clock pulse; data changes only while the clock is low.
    task clk_bit(input logic b, output logic s);
        sda_pull = ~b;
        #31;
        scl = 1'b1;
        #31;
        s = sda;
        #31.5;
        scl = 1'b0;
        #31.5;
    endtask : clk_bit
    // Start or repeated start, entered with the clock low or idle.
    task start_c();
        sda_pull = 1'b0;
        #31;
        scl = 1'b1;
        #31;
        sda_pull = 1'b1;
        #31;
        scl = 1'b0;
        #31;
    endtask : start_c
    // Stop condition leaves the bus idle.
    task stop_c();
        sda_pull = 1'b1;
        #31;
        scl = 1'b1;
        #31;
        sda_pull = 1'b0;
        #31;
    endtask : stop_c
    // Byte out, most significant bit first, then the acknowledge slot.
    task byte_w(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : byte_w
    // Byte in; a not-acknowledge ends every read, so one byte per read.
    task byte_r(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(1'b1, s);
    endtask : byte_r
    // Pointer write followed by one data byte.
    task wr(input logic [7:0] p, input logic [7:0] d, output logic ack);
        logic a0, a1, a2;
        start_c();
        byte_w(8'hA0, a0);
        byte_w(p, a1);
        byte_w(d, a2);
        stop_c();
        ack = a0 & a1 & a2;
    endtask : wr
    // Pointer write, repeated start and one byte read.
    task rd(input logic [7:0] p, output logic [7:0] d, output logic ack);
        logic a0, a1, a2;
        start_c();
        byte_w(8'hA0, a0);
        byte_w(p, a1);
        start_c();
        byte_w(8'hA1, a2);
        byte_r(d);
        stop_c();
        ack = a0 & a1 & a2;
    endtask : rd
endmodule : host_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench of the soft control block.
// Assumes: A short wake count keeps the run brief.
// Notes: Deadlines are checked well inside their documented bounds.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import soft_ctrl_pkg::*;
;
    localparam int WK = 20;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic sda_o, sda_oe, sel_n, rst_n, lp_in, int_n, prs_n, lp_st;
    logic scl, host_pull;
    logic [3:0] flag_cond;
    wire logic sda_line;
    int err_total = 0;
    int cmp_count = 0;
    // Open-drain data line with pull-up; either party may pull it low.
    assign sda_line = ~(host_pull | (sda_oe & ~sda_o));
    assign hready = hreadyout;
    soft_ctrl #(.WAKE_CYCLES(WK)) i_soft_ctrl (.hclk(hclk), .hresetn(hresetn),
        .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .module_select_line_n(sel_n), .module_reset_line_n(rst_n),
        .low_power_input(lp_in), .flag_cond(flag_cond),
        .interrupt_line_n(int_n), .presence_output_n(prs_n),
        .low_power_state(lp_st));
    host_model i_host_model (.scl(scl), .sda_pull(host_pull), .sda(sda_line));
    // Clock of 8 ns.
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task results();
        $display("Checks %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    // One single word transfer; waits on hready at both phases.
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task t_regs();
        logic [31:0] r;
        ahb(1'b0, REG_CTRL, 32'h0, r);
        chk("ctrl", 32'h00000050, r);
        ahb(1'b0, REG_IRQ_MASK, 32'h0, r);
        chk("irq_mask", 32'h00000000, r);
        ahb(1'b0, 8'h20, 32'h0, r);
        chk("unmapped", 32'h00000000, r);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("presence", 32'h0, {31'h0, prs_n});
        $display("Test regs done");
    endtask : t_regs
    task t_wake();
        logic [7:0] d;
        logic ack;
        cyc(WK + 50);
        chk("lp_wake", 32'h0, {31'h0, lp_st});
        chk("int_wake", 32'h0, {31'h0, int_n});
        sel_n <= 1'b0;
        cyc(20);
        i_host_model.rd(MEM_STATUS, d, ack);
        chk("ack_sel", 32'h1, {31'h0, ack});
        chk("not_ready", 32'h0, {31'h0, d[NOT_READY_BIT]});
        i_host_model.rd(MEM_FLAGS, d, ack);
        chk("ready_flag", 32'h1, {31'h0, d[FLAG_READY_BIT]});
        cyc(50);
        chk("int_clr", 32'h1, {31'h0, int_n});
        $display("Test wake done");
    endtask : t_wake
    task t_select();
        logic [31:0] r;
        logic ack;
        ahb(1'b1, REG_IRQ_STATUS, 32'h0000000F, r);
        sel_n <= 1'b1;
        cyc(20);
        i_host_model.wr(MEM_MASK, 8'h00, ack);
        chk("ack_desel", 32'h0, {31'h0, ack});
        sel_n <= 1'b0;
        cyc(20);
        i_host_model.wr(MEM_MASK, 8'h00, ack);
        chk("ack_resel", 32'h1, {31'h0, ack});
        ahb(1'b0, REG_IRQ_STATUS, 32'h0, r);
        chk("ev_select", 32'h1, {31'h0, r[EV_SELECT]});
        chk("ev_write", 32'h1, {31'h0, r[EV_WRITE]});
        chk("irq_masked", 32'h0, {31'h0, irq});
        ahb(1'b1, REG_IRQ_MASK, 32'h00000001, r);
        cyc(2);
        chk("irq_on", 32'h1, {31'h0, irq});
        ahb(1'b1, REG_IRQ_STATUS, 32'h00000001, r);
        cyc(2);
        chk("irq_w1c", 32'h0, {31'h0, irq});
        ahb(1'b1, REG_IRQ_MASK, 32'h00000000, r);
        $display("Test select done");
    endtask : t_select
    task t_mask();
        logic [31:0] r;
        logic [7:0] d;
        logic ack;
        flag_cond <= 4'h1;
        cyc(50);
        chk("int_flag", 32'h0, {31'h0, int_n});
        ahb(1'b0, REG_FLAGS, 32'h0, r);
        chk("flags_reg", 32'h00000002, r);
        i_host_model.wr(MEM_MASK, 8'hFF, ack);
        cyc(50);
        chk("int_masked", 32'h1, {31'h0, int_n});
        i_host_model.wr(MEM_MASK, 8'h00, ack);
        cyc(50);
        chk("int_unmask", 32'h0, {31'h0, int_n});
        flag_cond <= 4'h0;
        cyc(10);
        i_host_model.rd(MEM_FLAGS, d, ack);
        chk("flag_byte", 32'h02, {24'h0, d});
        cyc(50);
        chk("int_read", 32'h1, {31'h0, int_n});
        $display("Test mask done");
    endtask : t_mask
    task t_power();
        logic [31:0] r;
        logic [7:0] d;
        logic ack;
        for (int b = 0; b < 2; b++)
        begin
            i_host_model.wr(MEM_POWER, 8'h01 << b, ack);
            cyc(50);
            chk("lp_set", 32'h1, {31'h0, lp_st});
            i_host_model.wr(MEM_POWER, 8'h00, ack);
            cyc(WK + 50);
            chk("lp_clr", 32'h0, {31'h0, lp_st});
            ahb(1'b0, REG_STATE, 32'h0, r);
            chk("state_nr", 32'h0, {31'h0, r[1]});
            chk("int_full", 32'h0, {31'h0, int_n});
            i_host_model.rd(MEM_FLAGS, d, ack);
        end
        $display("Test power done");
    endtask : t_power
    task t_lpin();
        logic [7:0] d;
        logic ack;
        lp_in <= 1'b1;
        cyc(20);
        chk("lp_input", 32'h1, {31'h0, lp_st});
        lp_in <= 1'b0;
        cyc(WK + 50);
        chk("lp_input_off", 32'h0, {31'h0, lp_st});
        i_host_model.rd(MEM_FLAGS, d, ack);
        $display("Test low power input done");
    endtask : t_lpin
    task t_reset();
        rst_n <= 1'b0;
        cyc(100);
        chk("short_rst", 32'h0, {31'h0, lp_st});
        rst_n <= 1'b1;
        cyc(10);
        rst_n <= 1'b0;
        cyc(300);
        chk("long_rst", 32'h1, {31'h0, lp_st});
        rst_n <= 1'b1;
        cyc(WK + 50);
        chk("rst_wake", 32'h0, {31'h0, lp_st});
        $display("Test module reset done");
    endtask : t_reset
    // Main sequence; all inputs have values at time zero.
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {sel_n, rst_n, lp_in, flag_cond} = 7'h60;
        cyc(10);
        hresetn <= 1'b1;
        t_regs();
        t_wake();
        t_select();
        t_mask();
        t_power();
        t_lpin();
        t_reset();
        results();
    end
    // Watchdog: the run needs some 8,500 cycles; this allows 50,000.
    initial
    begin
        #400000;
        err_total++;
        results();
    end
endmodule : tb_top
`default_nettype wire
